// [bench/flash_command_sequencer_tb_top.sv]
// Self-checking testbench for the flash command sequencer host
`timescale 1ns/1ps
module flash_command_sequencer_tb_top;
  import flash_seq_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic fault = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic [31:0] reg_rdata;
  logic [31:0] rd;
  flash_pins_t pins;
  logic [DATA_W-1:0] dq_in;
  logic completion_pin;
  int n_mismatch = 0;
  int checks = 0;
  always #25 clk = ~clk;
  flash_seq_host uut (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pins(pins), .dq_in(dq_in), .completion_pin(completion_pin));
  flash_dev_model #(.BUSY_CYC(40)) dev (.clk(clk), .pins(pins), .fault(fault), .dq_in(dq_in),
    .completion_pin(completion_pin));
  ////////////////////////////////////////////////////////////////////////
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic cmp_flag(input logic got, input logic exp, input string what);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t %s flag: got %b expected %b", $time, what, got, exp);
    end
  endtask
  task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe, so sample just past that edge
  task automatic reg_read(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic wait_idle(output logic [31:0] st);
    int i;
    st = 32'h00000400;
    for (i = 0; i < 3000 && st[10] !== 1'b0; i++) reg_read(REG_STATUS, st);
    if (st[10] !== 1'b0) begin
      n_mismatch++;
      $display("ERROR %0t busy never cleared", $time);
      give_verdict();
    end
  endtask
  task automatic run_op(input op_t op, input logic [23:0] a, input logic [7:0] d, output logic [31:0] st);
    reg_write(REG_ADDR, {8'h00, a});
    reg_write(REG_DATA, {24'h000000, d});
    reg_write(REG_CTRL, {28'h0000000, op});
    repeat (3) @(posedge clk);
    wait_idle(st);
  endtask
  // Suspend is asked for well inside the device's busy time, so it must land mid-operation
  task automatic start_and_suspend(input string name, input op_t op, input logic [23:0] a);
    logic [31:0] st;
    reg_write(REG_ADDR, {8'h00, a});
    reg_write(REG_CTRL, {28'h0000000, op});
    repeat (20) @(posedge clk);
    reg_write(REG_CTRL, {28'h0000000, OP_SUSPEND});
    wait_idle(st);
    cmp({24'h000000, st[7:0]}, 32'h000000C0, name);
    $display("test %s done", name);
  endtask
  task automatic step(input string name, input op_t op, input logic [23:0] a, input logic [7:0] d,
                      input logic [7:0] exp, input logic exp_ref);
    logic [31:0] st;
    run_op(op, a, d, st);
    cmp({24'h000000, st[7:0]}, {24'h000000, exp}, name);
    cmp_flag(st[9], exp_ref, name);
    $display("test %s done", name);
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    reg_read(4'hF, rd);
    cmp(rd, 32'h0, "unmapped read");
    step("erase", OP_ERASE, 24'h020000, 8'h00, 8'h80, 1'b0);
    start_and_suspend("erase suspend", OP_ERASE, 24'h060000);
    step("erase while suspended", OP_ERASE, 24'h080000, 8'h00, 8'hC0, 1'b1);
    run_op(OP_READ, 24'h000033, 8'h00, rd);
    reg_read(REG_RDATA, rd);
    cmp({24'h000000, rd[7:0]}, 32'h00000069, "read while suspended");
    step("erase resume", OP_RESUME, 24'h0, 8'h00, 8'h80, 1'b0);
    start_and_suspend("program suspend", OP_PROGRAM, 24'h000050);
    step("program resume", OP_RESUME, 24'h0, 8'h00, 8'h80, 1'b0);
    step("suspend after finish", OP_SUSPEND, 24'h0, 8'h00, 8'h80, 1'b0);
    step("resume", OP_RESUME, 24'h0, 8'h00, 8'h80, 1'b0);
    step("program", OP_PROGRAM, 24'h000040, 8'h3C, 8'h80, 1'b0);
    run_op(OP_READ_ARRAY, 24'h0, 8'h00, rd);
    run_op(OP_READ, 24'h000040, 8'h00, rd);
    reg_read(REG_RDATA, rd);
    cmp({24'h000000, rd[7:0]}, 32'h0000001A, "array read");
    @(posedge clk);
    fault <= 1'b1;
    step("lock set fail", OP_LOCK_SET, 24'h020000, 8'h00, 8'h90, 1'b0);
    step("lock clear fail", OP_LOCK_CLEAR, 24'h0, 8'h00, 8'hB0, 1'b0);
    step("low supply program", OP_PROGRAM, 24'h000041, 8'h55, 8'hB8, 1'b0);
    @(posedge clk);
    fault <= 1'b0;
    step("program refused", OP_PROGRAM, 24'h000042, 8'h55, 8'hB8, 1'b1);
    step("clear status", OP_CLEAR_STATUS, 24'h0, 8'h00, 8'h80, 1'b0);
    step("lock set", OP_LOCK_SET, 24'h020000, 8'h00, 8'h80, 1'b0);
    step("lock clear", OP_LOCK_CLEAR, 24'h0, 8'h00, 8'h80, 1'b0);
    step("prot outside", OP_PROT_PROGRAM, 24'h000112, 8'hA5, 8'h80, 1'b1);
    step("prot inside", OP_PROT_PROGRAM, 24'h000111, 8'hA5, 8'h80, 1'b0);
    @(posedge clk);
    fault <= 1'b1;
    step("erase low supply", OP_ERASE, 24'h040000, 8'h00, 8'h88, 1'b0);
    @(posedge clk);
    fault <= 1'b0;
    step("device reset", OP_RESET, 24'h0, 8'h00, 8'h80, 1'b0);
    give_verdict();
  end
endmodule // flash_command_sequencer_tb_top

// [bench/flash_dev_model.sv]
// Behavioural model of the parallel flash device behind the host
`timescale 1ns/1ps
module flash_dev_model #(
  parameter int BUSY_CYC = 40
) (
  input wire logic clk,
  input wire flash_seq_pkg::flash_pins_t pins,
  input wire logic fault,
  output logic [flash_seq_pkg::DATA_W-1:0] dq_in,
  output logic completion_pin
);
  import flash_seq_pkg::*;
  logic [7:0] sr = 8'h80;
  logic [7:0] pend = 8'h00;
  logic [7:0] cmd = 8'h00;
  logic [7:0] last = 8'h00;
  logic [23:0] adr = 24'h000000;
  logic we_q = 1'b1;
  logic stat_mode = 1'b0;
  logic susp = 1'b0;
  int busy = 0;
  wire rpn = pins.reset_powerdown_n;
  wire sel = !pins.ce_n && !pins.oe_n && rpn;
  // Released bus shows the inverse of the last value; in status mode the live status shows on every enable
  assign dq_in = !sel ? ~last : (stat_mode ? sr : pins.addr[7:0] ^ 8'h5A);
  assign completion_pin = !(busy > 0 && !susp);
  ////////////////////////////////////////////////////////////////////////
  always @(posedge clk or negedge rpn) begin
    if (!rpn) begin
      sr <= 8'h80;
      pend <= 8'h00;
      stat_mode <= 1'b0;
      busy <= 0;
      susp <= 1'b0;
      we_q <= 1'b1;
    end else begin
      we_q <= pins.we_n;
      if (sel) last <= dq_in;
      if (!pins.we_n && !pins.ce_n) begin
        cmd <= pins.dq_out;
        adr <= pins.addr;
      end
      if (busy > 0 && !susp) begin
        busy <= busy - 1;
        if (busy == 1) sr[7] <= 1'b1;
      end
      if (!we_q && pins.we_n) begin
        stat_mode <= 1'b1;
        pend <= 8'h00;
        if (pend != 8'h00) begin
          if (pend != CMD_LOCK_SETUP && (fault || sr[3])) sr[3] <= 1'b1;
          else if ((pend == CMD_ERASE_SETUP && cmd != CMD_CONFIRM) ||
                   (pend == CMD_LOCK_SETUP && cmd != CMD_LOCK_SET && cmd != CMD_CONFIRM)) sr[5:4] <= 2'b11;
          else if (pend == CMD_PROT_SETUP && (adr < PROT_BASE || adr > PROT_LAST)) sr[4] <= 1'b1;
          else if (pend == CMD_LOCK_SETUP && fault) sr[cmd == CMD_LOCK_SET ? 4 : 5] <= 1'b1;
          else begin
            busy <= BUSY_CYC;
            sr[7] <= 1'b0;
          end
        end else begin
          case (cmd)
            CMD_READ_ARRAY: stat_mode <= 1'b0;
            CMD_CLEAR_STATUS: sr[5:1] <= 5'h00;
            CMD_SUSPEND: if (busy > 0) begin
              susp <= 1'b1;
              sr[7:6] <= 2'b11;
            end
            CMD_CONFIRM: if (susp) begin
              susp <= 1'b0;
              sr[7:6] <= 2'b00;
            end
            CMD_READ_STATUS: ;
            default: if (busy == 0) pend <= cmd;
          endcase
        end
      end
    end
  end
endmodule // flash_dev_model

// [bench/flash_seq_checker.sv]
// Port-level protocol checker for the flash command sequencer host
`timescale 1ns/1ps
module flash_seq_checker (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire flash_seq_pkg::flash_pins_t pins,
  input wire logic [flash_seq_pkg::DATA_W-1:0] dq_in,
  input wire logic completion_pin
);
  import flash_seq_pkg::*;
  logic [CNT_W-1:0] low_cnt_q;
  logic [CNT_W-1:0] low_cnt_d;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // Length of the device reset pulse, counted in clocks
  always_comb low_cnt_d = pins.reset_powerdown_n ? '0 : low_cnt_q + 1'b1;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) low_cnt_q <= '0;
    else low_cnt_q <= low_cnt_d;
  end
  ////////////////////////////////////////////////////////////////////////
  property p_rdata_idle; !$past(reg_rd) |-> reg_rdata == 32'h0; endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not zero outside read slot");
  property p_no_contention; !pins.oe_n |-> !pins.dq_oe; endproperty
  a_no_contention: assert property (p_no_contention) else $error("host drives data during a read");
  property p_write_frame; !pins.we_n |-> !pins.ce_n && pins.dq_oe && pins.oe_n; endproperty
  a_write_frame: assert property (p_write_frame) else $error("write strobe without select or data");
  property p_we_width; $fell(pins.we_n) |-> ##1 !pins.we_n ##1 pins.we_n; endproperty
  a_we_width: assert property (p_we_width) else $error("write strobe not two cycles");
  property p_oe_width; $fell(pins.oe_n) |-> ##1 !pins.oe_n ##1 !pins.oe_n ##1 pins.oe_n; endproperty
  a_oe_width: assert property (p_oe_width) else $error("read strobe not three cycles");
  property p_write_hold; $fell(pins.we_n) |=> $stable(pins.addr) && $stable(pins.dq_out); endproperty
  a_write_hold: assert property (p_write_hold) else $error("address or data moved under write");
  property p_reset_len; $rose(pins.reset_powerdown_n) |-> low_cnt_q == RP_CYC; endproperty
  a_reset_len: assert property (p_reset_len) else $error("device reset pulse has wrong length");
  property p_idle_after_reset;
    $rose(rst_b) |-> pins.ce_n && pins.we_n && pins.oe_n && !pins.dq_oe && pins.reset_powerdown_n;
  endproperty
  a_idle_after_reset: assert property (p_idle_after_reset) else $error("pins not idle after reset");
  property p_no_write_busy;
    !completion_pin && !$past(completion_pin, 3) |-> pins.we_n || pins.dq_out == CMD_SUSPEND;
  endproperty
  a_no_write_busy: assert property (p_no_write_busy) else $error("command written while device busy");
  c_erase: cover property ($fell(pins.we_n) && pins.dq_out == CMD_ERASE_SETUP);
  c_dev_reset: cover property ($rose(pins.reset_powerdown_n));
  c_busy: cover property ($fell(completion_pin));
  c_suspend: cover property ($fell(pins.we_n) && pins.dq_out == CMD_SUSPEND && !completion_pin);
endmodule // flash_seq_checker
bind flash_seq_host flash_seq_checker u_chk (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pins(pins), .dq_in(dq_in), .completion_pin(completion_pin));

// [core/flash_seq_host.sv]
// Host controller that drives a parallel NOR flash through its command sequences
//
// Function
// (R1) Suspend byte halts programming; check suspended flag
// (R2) While suspended, read array except target
// (R3) Resume byte restarts suspended operation
// (R4) Erase setup then confirm at block address
// (R5) No erase queuing; erase only when idle
// (R6) Erase suspend pauses; resume continues erase
// (R7) Ready flag high means machine idle
// (R8) Lock set: setup then set-confirm, poll ready
// (R9) Lock clear: setup then clear-confirm, poll
// (R10) Bits 5 and 4 both: sequence error
// (R11) Lock set failure bit 4, clear bit 5
// (R12) Low supply sets voltage error bit
// (R13) Error bits sticky until clear-status command
// (R14) Protection program only inside protection space
// (R15) Voltage error blocks programs until cleared
// (R16) Toggling enables refreshes status value
// (R17) Write read-array after last operation
// (R18) Completion pin low while operation runs
// (R19) Completion pin floats during suspend, reset
// (R20) Reset clears status; latch returns read-array
`timescale 1ns/1ps
module flash_seq_host
  import flash_seq_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output flash_seq_pkg::flash_pins_t pins,
  input wire logic [DATA_W-1:0] dq_in,
  input wire logic completion_pin
);
  import flash_seq_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  typedef enum logic [3:0] {
    S_IDLE = 4'h0,
    S_WR_SETUP = 4'h1,
    S_WR_SECOND = 4'h2,
    S_POLL = 4'h3,
    S_POLL_WAIT = 4'h4,
    S_RD_ARRAY = 4'h5,
    S_WR_SINGLE = 4'h6,
    S_RESET = 4'h7,
    S_GAP = 4'h8
  } state_t;

  state_t state_q, state_d;
  flash_pins_t pins_q, pins_d;
  op_t op_q, op_d;
  logic [ADDR_W-1:0] addr_q, addr_d;
  logic [DATA_W-1:0] data_q, data_d;
  logic [DATA_W-1:0] cmd1_q, cmd1_d, cmd2_q, cmd2_d;
  logic [DATA_W-1:0] fstat_q, fstat_d, rdata_q, rdata_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic [15:0] rst_cnt_q, rst_cnt_d;
  logic phase_q, phase_d;
  logic two_q, two_d;
  logic poll_q, poll_d;
  logic erase_act_q, erase_act_d;
  logic prog_act_q, prog_act_d;
  logic refused_q, refused_d;
  logic done_q, done_d;
  logic susp_req_q, susp_req_d;
  logic [31:0] reg_rdata_q, reg_rdata_d;
  logic [DATA_W-1:0] dq_s1_q, dq_s2_q;
  logic cp_s1_q, cp_s2_q;

  // Pin inputs pass two flip-flops first
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      dq_s1_q <= 8'h00;
      dq_s2_q <= 8'h00;
      cp_s1_q <= 1'b1;
      cp_s2_q <= 1'b1;
    end else begin
      dq_s1_q <= dq_in;
      dq_s2_q <= dq_s1_q;
      cp_s1_q <= completion_pin;
      cp_s2_q <= cp_s1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    state_d = state_q;
    pins_d = pins_q;
    op_d = op_q;
    addr_d = addr_q;
    data_d = data_q;
    cmd1_d = cmd1_q;
    cmd2_d = cmd2_q;
    fstat_d = fstat_q;
    rdata_d = rdata_q;
    cnt_d = cnt_q;
    rst_cnt_d = rst_cnt_q;
    phase_d = phase_q;
    two_d = two_q;
    poll_d = poll_q;
    erase_act_d = erase_act_q;
    prog_act_d = prog_act_q;
    refused_d = refused_q;
    done_d = done_q;
    susp_req_d = susp_req_q;
    reg_rdata_d = 32'h0000_0000;

    if (reg_wr && reg_addr == REG_ADDR) addr_d = reg_wdata[ADDR_W-1:0];
    if (reg_wr && reg_addr == REG_DATA) data_d = reg_wdata[DATA_W-1:0];
    if (reg_rd) begin
      unique case (reg_addr)
        REG_STATUS: reg_rdata_d = {21'h000000, state_q != S_IDLE, refused_q, done_q, fstat_q};
        REG_RDATA: reg_rdata_d = {24'h000000, rdata_q};
        REG_ADDR: reg_rdata_d = {8'h00, addr_q};
        default: reg_rdata_d = 32'h0000_0000;
      endcase
    end

    // A suspend is the one order taken while busy; it waits for a gap between two polls
    if (reg_wr && reg_addr == REG_CTRL && state_q != S_IDLE && op_t'(reg_wdata[3:0]) == OP_SUSPEND &&
        (op_q == OP_PROGRAM || op_q == OP_ERASE)) susp_req_d = 1'b1; // R1 R6

    unique case (state_q)
      S_IDLE: begin
        if (reg_wr && reg_addr == REG_CTRL) begin
          refused_d = 1'b0;
          two_d = 1'b0;
          poll_d = 1'b1;
          op_d = op_t'(reg_wdata[3:0]);
          unique case (op_t'(reg_wdata[3:0]))
            OP_PROGRAM: begin
              // Programs refused while supply error stands or another program is open
              if (fstat_q[SR_VPEN_ERR] || prog_act_q) refused_d = 1'b1; // R15
              else begin
                cmd1_d = CMD_PROGRAM_SETUP;
                cmd2_d = data_q;
                two_d = 1'b1;
                state_d = S_WR_SETUP;
              end
            end
            OP_ERASE: begin
              // Only one erase outstanding, suspended one included
              if (erase_act_q || prog_act_q) refused_d = 1'b1; // R5
              else begin
                cmd1_d = CMD_ERASE_SETUP; // R4
                cmd2_d = CMD_CONFIRM; // R4
                two_d = 1'b1;
                state_d = S_WR_SETUP;
              end
            end
            OP_SUSPEND: begin
              cmd1_d = CMD_SUSPEND; // R1 R6
              state_d = S_WR_SETUP;
            end
            OP_RESUME: begin
              cmd1_d = CMD_CONFIRM; // R3 R6
              state_d = S_WR_SETUP;
            end
            OP_LOCK_SET: begin
              cmd1_d = CMD_LOCK_SETUP; // R8
              cmd2_d = CMD_LOCK_SET; // R8
              two_d = 1'b1;
              state_d = S_WR_SETUP;
            end
            OP_LOCK_CLEAR: begin
              cmd1_d = CMD_LOCK_SETUP; // R9
              cmd2_d = CMD_CONFIRM; // R9
              two_d = 1'b1;
              state_d = S_WR_SETUP;
            end
            OP_PROT_PROGRAM: begin
              if (!in_prot_space(addr_q) || fstat_q[SR_VPEN_ERR]) refused_d = 1'b1; // R14 R15
              else begin
                cmd1_d = CMD_PROT_SETUP;
                cmd2_d = data_q;
                two_d = 1'b1;
                state_d = S_WR_SETUP;
              end
            end
            OP_CLEAR_STATUS: begin
              cmd1_d = CMD_CLEAR_STATUS; // R13
              state_d = S_WR_SETUP;
            end
            OP_READ_ARRAY, OP_READ: begin
              // Reading the suspended program target is not supported
              cmd1_d = CMD_READ_ARRAY; // R2 R17
              poll_d = 1'b0;
              state_d = S_WR_SETUP;
            end
            OP_RESET: begin
              rst_cnt_d = 16'(RP_CYC);
              pins_d.reset_powerdown_n = 1'b0; // R20
              state_d = S_RESET;
            end
            default: poll_d = 1'b0;
          endcase
          if (state_d != S_IDLE) done_d = 1'b0;
        end
      end
      S_WR_SETUP, S_WR_SECOND: begin
        // Write pulse: address, data and we_n low together, we_n held low for WE_CYC, then high
        if (!phase_q) begin
          pins_d.addr = addr_q;
          pins_d.dq_out = (state_q == S_WR_SETUP) ? cmd1_q : cmd2_q;
          pins_d.dq_oe = 1'b1;
          pins_d.ce_n = 1'b0;
          pins_d.we_n = 1'b0;
          cnt_d = CNT_W'(WE_CYC);
          phase_d = 1'b1;
        end else if (cnt_q > CNT_W'(1)) cnt_d = cnt_q - CNT_W'(1);
        else begin
          pins_d.we_n = 1'b1;
          pins_d.ce_n = 1'b1;
          phase_d = 1'b0;
          if (state_q == S_WR_SETUP && two_q) state_d = S_WR_SECOND;
          else state_d = S_GAP;
        end
      end
      S_GAP: begin
        pins_d.dq_oe = 1'b0;
        if (op_q == OP_ERASE) erase_act_d = 1'b1;
        if (op_q == OP_PROGRAM || op_q == OP_PROT_PROGRAM) prog_act_d = 1'b1;
        state_d = (op_q == OP_READ) ? S_RD_ARRAY : (poll_q ? S_POLL : S_IDLE);
        if (!poll_q && op_q != OP_READ) done_d = 1'b1;
      end
      S_POLL, S_RD_ARRAY: begin
        // Each ce/oe low cycle refreshes the status shown by the flash
        if (!phase_q) begin
          pins_d.ce_n = 1'b0; // R16
          pins_d.oe_n = 1'b0; // R16
          cnt_d = CNT_W'(RD_CYC);
          phase_d = 1'b1;
        end else if (cnt_q > CNT_W'(1)) cnt_d = cnt_q - CNT_W'(1);
        else begin
          pins_d.ce_n = 1'b1;
          pins_d.oe_n = 1'b1;
          phase_d = 1'b0;
          if (state_q == S_RD_ARRAY) begin
            rdata_d = dq_s2_q;
            done_d = 1'b1;
            state_d = S_IDLE;
          end else state_d = S_POLL_WAIT;
        end
      end
      S_POLL_WAIT: begin
        // Pin low means busy; poll byte decides once ready
        if (dq_s2_q[SR_READY] && cp_s2_q) begin // R7 R18 R19
          susp_req_d = 1'b0;
          fstat_d = dq_s2_q; // R10 R11 R12
          done_d = 1'b1;
          state_d = S_IDLE;
          if (!dq_s2_q[SR_SUSP]) begin // R1 R6
            if (op_q != OP_SUSPEND || !prog_act_q) erase_act_d = 1'b0;
            prog_act_d = 1'b0;
          end
        end else if (susp_req_q) begin
          // Sent with both strobes high, so no read cycle is cut short
          cmd1_d = CMD_SUSPEND; // R1 R6
          two_d = 1'b0;
          op_d = OP_SUSPEND;
          susp_req_d = 1'b0;
          state_d = S_WR_SETUP;
        end else state_d = S_POLL;
      end
      S_RESET: begin
        if (rst_cnt_q > 16'h0001) rst_cnt_d = rst_cnt_q - 16'h0001;
        else begin
          pins_d.reset_powerdown_n = 1'b1;
          fstat_d = 8'h80; // R20
          erase_act_d = 1'b0;
          prog_act_d = 1'b0;
          done_d = 1'b1;
          state_d = S_IDLE;
        end
      end
      default: state_d = S_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= S_IDLE;
      pins_q <= '{addr: 24'h000000, dq_out: 8'h00, dq_oe: 1'b0, ce_n: 1'b1, oe_n: 1'b1,
                  we_n: 1'b1, reset_powerdown_n: 1'b1};
      op_q <= OP_NONE;
      addr_q <= 24'h000000;
      data_q <= 8'h00;
      cmd1_q <= 8'h00;
      cmd2_q <= 8'h00;
      fstat_q <= 8'h80;
      rdata_q <= 8'h00;
      cnt_q <= 10'h000;
      rst_cnt_q <= 16'h0000;
      phase_q <= 1'b0;
      two_q <= 1'b0;
      poll_q <= 1'b0;
      erase_act_q <= 1'b0;
      prog_act_q <= 1'b0;
      refused_q <= 1'b0;
      done_q <= 1'b0;
      susp_req_q <= 1'b0;
      reg_rdata_q <= 32'h0000_0000;
    end else begin
      state_q <= state_d;
      pins_q <= pins_d;
      op_q <= op_d;
      addr_q <= addr_d;
      data_q <= data_d;
      cmd1_q <= cmd1_d;
      cmd2_q <= cmd2_d;
      fstat_q <= fstat_d;
      rdata_q <= rdata_d;
      cnt_q <= cnt_d;
      rst_cnt_q <= rst_cnt_d;
      phase_q <= phase_d;
      two_q <= two_d;
      poll_q <= poll_d;
      erase_act_q <= erase_act_d;
      prog_act_q <= prog_act_d;
      refused_q <= refused_d;
      done_q <= done_d;
      susp_req_q <= susp_req_d;
      reg_rdata_q <= reg_rdata_d;
    end
  end

  assign pins = pins_q;
  assign reg_rdata = reg_rdata_q;
endmodule // flash_seq_host

// [core/flash_seq_pkg.sv]
// Package for the flash command sequencer host controller
package flash_seq_pkg;
  // Flash command bytes
  localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;
  localparam logic [7:0] CMD_READ_STATUS = 8'h70;
  localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
  localparam logic [7:0] CMD_SUSPEND = 8'hB0;
  localparam logic [7:0] CMD_CONFIRM = 8'hD0;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h20;
  localparam logic [7:0] CMD_LOCK_SETUP = 8'h60;
  localparam logic [7:0] CMD_LOCK_SET = 8'h01;
  localparam logic [7:0] CMD_PROT_SETUP = 8'hC0;
  localparam logic [7:0] CMD_PROGRAM_SETUP = 8'h40;

  // Status bit positions in the flash status byte
  localparam int SR_READY = 7;
  localparam int SR_SUSP = 6;
  localparam int SR_ERASE_ERR = 5;
  localparam int SR_PROG_ERR = 4;
  localparam int SR_VPEN_ERR = 3;
  localparam int SR_PROTECT = 1;

  localparam int ADDR_W = 24;
  localparam int DATA_W = 8;

  // Host register map (word index on the software port)
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_ADDR = 4'h1;
  localparam logic [3:0] REG_DATA = 4'h2;
  localparam logic [3:0] REG_STATUS = 4'h3;
  localparam logic [3:0] REG_RDATA = 4'h4;

  // Operation codes written to the control register
  typedef enum logic [3:0] {
    OP_NONE = 4'h0,
    OP_READ = 4'h1,
    OP_PROGRAM = 4'h2,
    OP_ERASE = 4'h3,
    OP_SUSPEND = 4'h4,
    OP_RESUME = 4'h5,
    OP_LOCK_SET = 4'h6,
    OP_LOCK_CLEAR = 4'h7,
    OP_PROT_PROGRAM = 4'h8,
    OP_CLEAR_STATUS = 4'h9,
    OP_READ_ARRAY = 4'hA,
    OP_RESET = 4'hB
  } op_t;

  // Protection register window: A8 set, A23..A9 clear, low bits up to 11h
  localparam logic [ADDR_W-1:0] PROT_BASE = 24'h000100;
  localparam logic [ADDR_W-1:0] PROT_LAST = 24'h000111;

  // Bus timing at 20 MHz
  localparam int CLK_NS = 50;
  localparam int T_WE_NS = 70;
  localparam int T_RD_NS = 150;
  localparam int T_RP_NS = 35000;
  localparam int WE_CYC = (T_WE_NS + CLK_NS - 1) / CLK_NS;
  localparam int RD_CYC = (T_RD_NS + CLK_NS - 1) / CLK_NS;
  localparam int RP_CYC = (T_RP_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W = 10;

  // Pins toward the flash
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] dq_out;
    logic dq_oe;
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic reset_powerdown_n;
  } flash_pins_t;

  // Host-side status word
  typedef struct packed {
    logic busy;
    logic refused;
    logic completion_seen;
    logic [DATA_W-1:0] flash_status;
  } host_status_t;

  function automatic logic in_prot_space(input logic [ADDR_W-1:0] a);
    return (a >= PROT_BASE) && (a <= PROT_LAST);
  endfunction
endpackage
